// ### bench/msc_chk_asserts.sv
// Assertions on the command interpreter ports.
`timescale 1ns/1ps
`default_nettype none
module msc_chk (
   input wire mclk,
   input wire sys_rst,
   input wire cmd_valid,
   input wire [3:0] cmd_op,
   input wire [15:0] cmd_param,
   input wire cal_mode_pin,
   input wire [15:0] rsp_data,
   input wire rsp_valid,
   input wire cmd_done,
   input wire cmd_error,
   input wire [6:0] avg_count,
   input wire auto_comp_on,
   input wire manual_offset_mode,
   input wire zero_start,
   input wire err_avail
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   property p_done; cmd_valid |=> cmd_done; endproperty
   a_done: assert property (p_done) else $error("no done pulse");
   property p_avg; avg_count >= 7'h01 && avg_count <= 7'h63; endproperty
   a_avg: assert property (p_avg) else $error("count out of range");
   property p_range;
      cmd_valid && cmd_op == 4'h1 && (cmd_param == 16'h0000 || cmd_param > 16'h0063)
      |=> cmd_error && $stable(avg_count);
   endproperty
   a_range: assert property (p_range) else $error("bad count taken");
   property p_man; manual_offset_mode != auto_comp_on; endproperty
   a_man: assert property (p_man) else $error("mode mismatch");
   property p_zero; zero_start |-> $past(cmd_valid) && $past(cmd_op) == 4'h3; endproperty
   a_zero: assert property (p_zero) else $error("stray zero start");
   property p_tst; cmd_valid && cmd_op == 4'he |=> rsp_valid && rsp_data == 16'h0001; endproperty
   a_tst: assert property (p_tst) else $error("self test answer");
   property p_opc; cmd_valid && cmd_op == 4'hc |=> !cmd_error && !rsp_valid && $stable(avg_count); endproperty
   a_opc: assert property (p_opc) else $error("opc had effect");
   property p_rst; cmd_valid && cmd_op == 4'hd |=> avg_count == 7'h01 && auto_comp_on; endproperty
   a_rst: assert property (p_rst) else $error("reset values");
   // The pin passes two flops, so it must have been high for two edges already.
   property p_cal;
      cmd_valid && cmd_op == 4'h1 && $past(cal_mode_pin) && $past(cal_mode_pin, 2)
      && !$past(sys_rst) && !$past(sys_rst, 2) |=> cmd_error;
   endproperty
   a_cal: assert property (p_cal) else $error("cal mode not refused");
   property p_err; cmd_error && !cmd_valid |=> err_avail; endproperty
   a_err: assert property (p_err) else $error("error not logged");
endmodule // msc_chk
bind msc_cmd msc_chk u_chk (
   .mclk(mclk),
   .sys_rst(sys_rst),
   .cmd_valid(cmd_valid),
   .cmd_op(cmd_op),
   .cmd_param(cmd_param),
   .cal_mode_pin(cal_mode_pin),
   .rsp_data(rsp_data),
   .rsp_valid(rsp_valid),
   .cmd_done(cmd_done),
   .cmd_error(cmd_error),
   .avg_count(avg_count),
   .auto_comp_on(auto_comp_on),
   .manual_offset_mode(manual_offset_mode),
   .zero_start(zero_start),
   .err_avail(err_avail)
);
`default_nettype wire

// ### bench/msc_host.sv
// Remote host model that issues one command at a time.
`timescale 1ns/1ps
`default_nettype none
module msc_host (
   input wire logic mclk,
   output var logic cmd_valid,
   output var logic [3:0] cmd_op,
   output var logic [15:0] cmd_param
);
   initial begin
      cmd_valid = 1'b0;
      cmd_op = 4'h0;
      cmd_param = 16'h0000;
   end
   // Idle slots carry inverted values, so a design that ignores cmd_valid is caught.
   task automatic send(input logic [3:0] op, input logic [15:0] prm, input int gap);
      repeat (gap) @(posedge mclk);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_param <= prm;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      cmd_op <= ~op;
      cmd_param <= ~prm;
   endtask
endmodule // msc_host
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the command interpreter.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic mclk, sys_rst, cal_mode_pin, meas_busy_pin, oper_event_in, ques_event_in, err_pop;
   wire logic cmd_valid, rsp_valid, cmd_done, cmd_error, auto_comp_on, manual_offset_mode;
   wire logic zero_start, oper_event_reg, ques_event_reg, err_avail;
   wire logic [3:0] cmd_op;
   wire logic [15:0] cmd_param, rsp_data;
   wire logic [6:0] avg_count;
   wire logic [7:0] err_code;
   int err_total, checks;
   msc_host host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_param(cmd_param));
   msc_cmd dut (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .cmd_valid(cmd_valid),
      .cmd_op(cmd_op),
      .cmd_param(cmd_param),
      .cal_mode_pin(cal_mode_pin),
      .meas_busy_pin(meas_busy_pin),
      .oper_event_in(oper_event_in),
      .ques_event_in(ques_event_in),
      .err_pop(err_pop),
      .rsp_data(rsp_data),
      .rsp_valid(rsp_valid),
      .cmd_done(cmd_done),
      .cmd_error(cmd_error),
      .avg_count(avg_count),
      .auto_comp_on(auto_comp_on),
      .manual_offset_mode(manual_offset_mode),
      .zero_start(zero_start),
      .oper_event_reg(oper_event_reg),
      .ques_event_reg(ques_event_reg),
      .err_code(err_code),
      .err_avail(err_avail)
   );
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [3:0] op, input logic [15:0] prm, input logic xerr);
      host.send(op, prm, checks % 3);
      #1;
      chk({15'h0, cmd_done}, 16'h0001);
      chk({15'h0, cmd_error}, {15'h0, xerr});
   endtask
   task automatic qry(input logic [3:0] op, input logic [15:0] exp);
      cmd(op, 16'h0000, 1'b0);
      chk({15'h0, rsp_valid}, 16'h0001);
      chk(rsp_data, exp);
   endtask
   task automatic pins(input logic cal, input logic busy);
      cal_mode_pin <= cal;
      meas_busy_pin <= busy;
      repeat (3) @(posedge mclk);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      summarize;
   end
   initial begin
      sys_rst = 1'b1;
      {cal_mode_pin, meas_busy_pin, oper_event_in, ques_event_in, err_pop} = 5'h00;
      err_total = 0;
      checks = 0;
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      qry(4'h2, 16'h0001);
      qry(4'h5, 16'h0001);
      qry(4'h7, 16'h0000);
      qry(4'ha, 16'h0000);
      $display("test reset done");
      cmd(4'h1, 16'h0063, 1'b0);
      cmd(4'h1, 16'h0000, 1'b1);
      cmd(4'h1, 16'h0064, 1'b1);
      qry(4'h2, 16'h0063);
      chk({9'h000, avg_count}, 16'h0063);
      cmd(4'h4, 16'h0000, 1'b0);
      chk({15'h0, manual_offset_mode}, 16'h0001);
      chk({15'h0, auto_comp_on}, 16'h0000);
      qry(4'h5, 16'h0000);
      cmd(4'h3, 16'h0000, 1'b0);
      chk({15'h0, zero_start}, 16'h0001);
      cmd(4'h4, 16'h0002, 1'b1);
      $display("test sense done");
      for (int m = 0; m < 2; m++) begin
         pins(m == 0, m == 1);
         cmd(4'h1, 16'h0005, 1'b1);
         cmd(4'h3, 16'h0000, 1'b1);
         chk({15'h0, zero_start}, 16'h0000);
         cmd(4'h4, 16'h0001, 1'b1);
      end
      pins(1'b0, 1'b0);
      qry(4'h2, 16'h0063);
      qry(4'h5, 16'h0000);
      $display("test refuse done");
      cmd(4'h6, 16'h00ff, 1'b0);
      cmd(4'h6, 16'h0100, 1'b1);
      qry(4'h7, 16'h00ff);
      cmd(4'h9, 16'h0030, 1'b0);
      qry(4'ha, 16'h0030);
      cmd(4'h0, 16'h0000, 1'b1);
      {oper_event_in, ques_event_in} <= 2'h3;
      @(posedge mclk);
      {oper_event_in, ques_event_in} <= 2'h0;
      qry(4'h8, 16'h0064);
      cmd(4'h6, 16'h0004, 1'b0);
      qry(4'h8, 16'h0064);
      qry(4'hb, 16'h0030);
      qry(4'hb, 16'h0000);
      err_pop <= 1'b1;
      @(posedge mclk);
      err_pop <= 1'b0;
      @(posedge mclk);
      #1;
      chk({8'h00, err_code}, 16'h0001);
      $display("test status done");
      cmd(4'hc, 16'h0000, 1'b0);
      chk({15'h0, rsp_valid}, 16'h0000);
      qry(4'h2, 16'h0063);
      cmd(4'hd, 16'h0000, 1'b0);
      qry(4'h2, 16'h0001);
      qry(4'h5, 16'h0001);
      qry(4'he, 16'h0001);
      chk({14'h0, oper_event_reg, ques_event_reg}, 16'h0003);
      cmd(4'hf, 16'h0000, 1'b0);
      @(posedge mclk);
      #1;
      chk({13'h0, err_avail, oper_event_reg, ques_event_reg}, 16'h0000);
      qry(4'h8, 16'h0000);
      qry(4'hb, 16'h0000);
      $display("test common done");
      summarize;
   end
endmodule // tb_top
`default_nettype wire

// ### common/msc_defs.vh
// Constants for the sense and status command interpreter.
`ifndef MSC_DEFS_VH
`define MSC_DEFS_VH
`define MSC_OP_AVG_SET 4'h1
`define MSC_OP_AVG_QRY 4'h2
`define MSC_OP_ZERO 4'h3
`define MSC_OP_COMP_SET 4'h4
`define MSC_OP_COMP_QRY 4'h5
`define MSC_OP_SRE_SET 4'h6
`define MSC_OP_SRE_QRY 4'h7
`define MSC_OP_STB_QRY 4'h8
`define MSC_OP_ESE_SET 4'h9
`define MSC_OP_ESE_QRY 4'ha
`define MSC_OP_ESR_QRY 4'hb
`define MSC_OP_OPC 4'hc
`define MSC_OP_RST 4'hd
`define MSC_OP_TST_QRY 4'he
`define MSC_OP_CLS 4'hf
`define MSC_AVG_MIN 16'h0001
`define MSC_AVG_MAX 16'h0063
`define MSC_BYTE_MAX 16'h00ff
`define MSC_AVG_RST 7'h01
`define MSC_COMP_RST 1'b1
`define MSC_SRE_RST 8'h00
`define MSC_ESE_RST 8'h00
`define MSC_TST_ANSWER 16'h0001
`define MSC_ERR_RANGE 8'h01
`define MSC_ERR_MODE 8'h02
`define MSC_ERR_UNKNOWN 8'h03
`define MSC_ESR_EXE_BIT 4
`define MSC_ESR_CMD_BIT 5
`define MSC_STB_EAV_BIT 2
`define MSC_STB_ESB_BIT 5
`define MSC_STB_MSS_BIT 6
`endif

// ### design/msc_cmd.v
// Sense setting and standard status command interpreter.
`timescale 1ns/1ps
`default_nettype none
`include "msc_defs.vh"
// Overview of operation
// - The averaging count accepts and reports only whole values from 1 to 99.
// - Averaging-count, zero-offset and compensation commands are refused in calibration mode or during a measurement.
// - The zero-offset command starts a zero-offset measurement for manual offset mode, with no parameter and no query.
// - The compensation command turns automatic compensation on for 1 and off for 0, and its query answers 1 or 0.
// - A written service-request enable value from 0 to 255 is stored and returned by its query.
// - The status byte is read only by query and answers a value from 0 to 255.
// - A written event-status enable value from 0 to 255 is stored and returned by its query.
// - The standard event-status register is read only by query and answers a value from 0 to 255.
// - The operation-complete command is accepted and does nothing.
// - The reset command restores the averaging count and compensation to their initial state but leaves the status enables and serial port setup alone.
// - The self-test query runs no test and always answers 1.
// - The clear-status command empties the error buffer and zeroes the status byte and all event registers.
module msc_cmd #(
   parameter ERR_DEPTH_LOG2 = 3
) (
   input wire mclk,
   input wire sys_rst,
   input wire cmd_valid,
   input wire [3:0] cmd_op,
   input wire [15:0] cmd_param,
   input wire cal_mode_pin,
   input wire meas_busy_pin,
   input wire oper_event_in,
   input wire ques_event_in,
   input wire err_pop,
   output reg [15:0] rsp_data,
   output reg rsp_valid,
   output reg cmd_done,
   output reg cmd_error,
   output reg [6:0] avg_count,
   output reg auto_comp_on,
   output reg manual_offset_mode,
   output reg zero_start,
   output reg oper_event_reg,
   output reg ques_event_reg,
   output reg [7:0] err_code,
   output reg err_avail
);
   reg [7:0] sre_reg;
   reg [7:0] ese_reg;
   reg [7:0] esr_reg;
   reg [7:0] sre_next;
   reg [7:0] ese_next;
   reg [7:0] esr_next;
   reg [6:0] avg_next;
   reg comp_next;
   reg zero_next;
   reg [15:0] rsp_next;
   reg rsp_v_next;
   reg err_next;
   reg [7:0] err_code_next;
   reg push_next;
   reg cls_next;
   wire cal_mode;
   wire meas_busy;
   wire buf_not_empty;
   wire [7:0] buf_code;
   reg [7:0] stb_value;
   reg [7:0] stb_sum;
   wire restricted;
   wire locked;
   wire ess_bit;

   msc_sync u_sync_cal (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .d_in(cal_mode_pin),
      .q_out(cal_mode)
   );
   msc_sync u_sync_busy (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .d_in(meas_busy_pin),
      .q_out(meas_busy)
   );
   msc_err_buf #(
      .DEPTH_LOG2(ERR_DEPTH_LOG2)
   ) u_err (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .clear(cls_next),
      .push(push_next),
      .push_code(err_code_next),
      .pop(err_pop),
      .pop_code(buf_code),
      .not_empty(buf_not_empty)
   );

   // The status byte is assembled live from its summaries so it never goes stale.
   assign ess_bit = |(esr_reg & ese_reg);
   // Bits sit at their named positions, so the service mask always lines up with the byte it reads.
   always @* begin
      stb_sum = 8'h00;
      stb_sum[`MSC_STB_EAV_BIT] = buf_not_empty;
      stb_sum[`MSC_STB_ESB_BIT] = ess_bit;
      stb_value = stb_sum;
      stb_value[`MSC_STB_MSS_BIT] = |(stb_sum & sre_reg);
   end
   assign restricted = (cmd_op == `MSC_OP_AVG_SET) || (cmd_op == `MSC_OP_ZERO) ||
      (cmd_op == `MSC_OP_COMP_SET);
   assign locked = cal_mode || meas_busy;

   always @* begin
      sre_next = sre_reg;
      ese_next = ese_reg;
      esr_next = esr_reg;
      avg_next = avg_count;
      comp_next = auto_comp_on;
      zero_next = 1'b0;
      rsp_next = rsp_data;
      rsp_v_next = 1'b0;
      err_next = 1'b0;
      err_code_next = 8'h00;
      push_next = 1'b0;
      cls_next = 1'b0;
      if (cmd_valid) begin
         if (restricted && locked) begin
            err_next = 1'b1;
            err_code_next = `MSC_ERR_MODE;
            esr_next[`MSC_ESR_EXE_BIT] = 1'b1;
         end else begin
            case (cmd_op)
               `MSC_OP_AVG_SET: begin
                  if (cmd_param >= `MSC_AVG_MIN && cmd_param <= `MSC_AVG_MAX) begin
                     avg_next = cmd_param[6:0];
                  end else begin
                     err_next = 1'b1;
                     err_code_next = `MSC_ERR_RANGE;
                     esr_next[`MSC_ESR_EXE_BIT] = 1'b1;
                  end
               end
               `MSC_OP_AVG_QRY: begin
                  rsp_next = {9'h000, avg_count};
                  rsp_v_next = 1'b1;
               end
               `MSC_OP_ZERO: begin
                  zero_next = 1'b1;
               end
               `MSC_OP_COMP_SET: begin
                  if (cmd_param <= 16'h0001) begin
                     comp_next = cmd_param[0];
                  end else begin
                     err_next = 1'b1;
                     err_code_next = `MSC_ERR_RANGE;
                     esr_next[`MSC_ESR_EXE_BIT] = 1'b1;
                  end
               end
               `MSC_OP_COMP_QRY: begin
                  rsp_next = {15'h0000, auto_comp_on};
                  rsp_v_next = 1'b1;
               end
               `MSC_OP_SRE_SET: begin
                  if (cmd_param <= `MSC_BYTE_MAX) begin
                     sre_next = cmd_param[7:0];
                  end else begin
                     err_next = 1'b1;
                     err_code_next = `MSC_ERR_RANGE;
                     esr_next[`MSC_ESR_EXE_BIT] = 1'b1;
                  end
               end
               `MSC_OP_SRE_QRY: begin
                  rsp_next = {8'h00, sre_reg};
                  rsp_v_next = 1'b1;
               end
               `MSC_OP_STB_QRY: begin
                  rsp_next = {8'h00, stb_value};
                  rsp_v_next = 1'b1;
               end
               `MSC_OP_ESE_SET: begin
                  if (cmd_param <= `MSC_BYTE_MAX) begin
                     ese_next = cmd_param[7:0];
                  end else begin
                     err_next = 1'b1;
                     err_code_next = `MSC_ERR_RANGE;
                     esr_next[`MSC_ESR_EXE_BIT] = 1'b1;
                  end
               end
               `MSC_OP_ESE_QRY: begin
                  rsp_next = {8'h00, ese_reg};
                  rsp_v_next = 1'b1;
               end
               `MSC_OP_ESR_QRY: begin
                  rsp_next = {8'h00, esr_reg};
                  rsp_v_next = 1'b1;
                  esr_next = 8'h00;
               end
               `MSC_OP_OPC: begin
                  rsp_next = rsp_data;
               end
               `MSC_OP_RST: begin
                  // Only the measurement settings go back; status and serial setup are kept.
                  avg_next = `MSC_AVG_RST;
                  comp_next = `MSC_COMP_RST;
               end
               `MSC_OP_TST_QRY: begin
                  rsp_next = `MSC_TST_ANSWER;
                  rsp_v_next = 1'b1;
               end
               `MSC_OP_CLS: begin
                  cls_next = 1'b1;
                  esr_next = 8'h00;
               end
               default: begin
                  err_next = 1'b1;
                  err_code_next = `MSC_ERR_UNKNOWN;
                  esr_next[`MSC_ESR_CMD_BIT] = 1'b1;
               end
            endcase
         end
         push_next = err_next;
      end
   end

   always @(posedge mclk) begin
      if (sys_rst) begin
         sre_reg <= `MSC_SRE_RST;
         ese_reg <= `MSC_ESE_RST;
         esr_reg <= 8'h00;
         avg_count <= `MSC_AVG_RST;
         auto_comp_on <= `MSC_COMP_RST;
         manual_offset_mode <= ~`MSC_COMP_RST;
         zero_start <= 1'b0;
         rsp_data <= 16'h0000;
         rsp_valid <= 1'b0;
         cmd_done <= 1'b0;
         cmd_error <= 1'b0;
         oper_event_reg <= 1'b0;
         ques_event_reg <= 1'b0;
         err_code <= 8'h00;
         err_avail <= 1'b0;
      end else begin
         sre_reg <= sre_next;
         ese_reg <= ese_next;
         esr_reg <= esr_next;
         avg_count <= avg_next;
         auto_comp_on <= comp_next;
         manual_offset_mode <= ~comp_next;
         zero_start <= zero_next;
         rsp_data <= rsp_next;
         rsp_valid <= rsp_v_next;
         cmd_done <= cmd_valid;
         cmd_error <= err_next;
         // A new event in the clear cycle survives the clear.
         oper_event_reg <= oper_event_in | (oper_event_reg & ~cls_next);
         ques_event_reg <= ques_event_in | (ques_event_reg & ~cls_next);
         err_code <= buf_code;
         err_avail <= buf_not_empty;
      end
   end
endmodule // msc_cmd
`default_nettype wire

// ### design/msc_err_buf.v
// Error code buffer with registered read data.
`timescale 1ns/1ps
`default_nettype none
module msc_err_buf #(
   parameter DEPTH_LOG2 = 3
) (
   input wire mclk,
   input wire sys_rst,
   input wire clear,
   input wire push,
   input wire [7:0] push_code,
   input wire pop,
   output reg [7:0] pop_code,
   output wire not_empty
);
   localparam DEPTH = 1 << DEPTH_LOG2;
   reg [7:0] mem [0:DEPTH-1];
   reg [DEPTH_LOG2-1:0] wr_reg;
   reg [DEPTH_LOG2-1:0] rd_reg;
   reg [DEPTH_LOG2:0] cnt_reg;
   wire do_push;
   wire do_pop;
   // When full, newest errors are dropped so the oldest stay readable.
   assign do_push = push && (cnt_reg != DEPTH[DEPTH_LOG2:0]);
   assign do_pop = pop && (cnt_reg != {(DEPTH_LOG2+1){1'b0}});
   assign not_empty = (cnt_reg != {(DEPTH_LOG2+1){1'b0}});
   always @(posedge mclk) begin
      if (do_push && !clear) begin
         mem[wr_reg] <= push_code;
      end
   end
   always @(posedge mclk) begin
      if (sys_rst || clear) begin
         wr_reg <= {DEPTH_LOG2{1'b0}};
         rd_reg <= {DEPTH_LOG2{1'b0}};
         cnt_reg <= {(DEPTH_LOG2+1){1'b0}};
         pop_code <= 8'h00;
      end else begin
         if (do_push) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (do_pop) begin
            rd_reg <= rd_reg + 1'b1;
            pop_code <= mem[rd_reg];
         end else if (pop) begin
            pop_code <= 8'h00;
         end
         cnt_reg <= cnt_reg + {{DEPTH_LOG2{1'b0}}, do_push} - {{DEPTH_LOG2{1'b0}}, do_pop};
      end
   end
endmodule // msc_err_buf
`default_nettype wire

// ### design/msc_sync.v
// Two-flop synchroniser for pin-level inputs.
`timescale 1ns/1ps
`default_nettype none
module msc_sync (
   input wire mclk,
   input wire sys_rst,
   input wire d_in,
   output reg q_out
);
   reg meta_reg;
   always @(posedge mclk) begin
      if (sys_rst) begin
         meta_reg <= 1'b0;
         q_out <= 1'b0;
      end else begin
         meta_reg <= d_in;
         q_out <= meta_reg;
      end
   end
endmodule // msc_sync
`default_nettype wire
